// ===== rtl/accel_ctrl_pkg.sv
// package: constants, register map and types for the acceleration sensor control block
package accel_ctrl_pkg;

   // clock and times, all in nanoseconds
   localparam int CLK_PERIOD_NS   = 40;
   localparam int RESET_REQ_NS    = 512000;   // reset pin low with serial clock high
   localparam int STATUS_HIZ_NS   = 800000;   // status pin floats after a device reset
   localparam int STAB_DELAY_NS   = 3000000;  // stabilization delay, status cannot clear
   localparam int SAMPLE_NS       = 16000;    // one filtered sample per axis

   // least times round up, longest times round down
   localparam int RESET_REQ_CYC   = (RESET_REQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STATUS_HIZ_CYC  = STATUS_HIZ_NS / CLK_PERIOD_NS;
   localparam int STAB_DELAY_CYC  = (STAB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAMPLE_CYC      = SAMPLE_NS / CLK_PERIOD_NS;

   localparam int CNT_W           = 17;
   localparam int SAMPLE_CNT_W    = 9;
   localparam int DATA_W          = 12;
   localparam int ADDR_W          = 8;
   localparam int NUM_PINS        = 2;

   // synchronised pin indices
   localparam int PIN_SELF_TEST   = 0;
   localparam int PIN_HOLD        = 1;

   // register byte addresses
   localparam logic [ADDR_W-1:0] CTRL_ADDR   = 8'h00;
   localparam logic [ADDR_W-1:0] IRQ_ADDR    = 8'h04;
   localparam logic [ADDR_W-1:0] MASK_ADDR   = 8'h08;
   localparam logic [ADDR_W-1:0] STATE_ADDR  = 8'h0c;
   localparam logic [ADDR_W-1:0] XDATA_ADDR  = 8'h10;
   localparam logic [ADDR_W-1:0] YDATA_ADDR  = 8'h14;

   // control register fields
   localparam int CTRL_POLARITY   = 0;
   localparam int CTRL_TEST_MODE  = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // interrupt status and mask fields
   localparam int IRQ_W           = 3;
   localparam int IRQ_STATUS_SET  = 0;
   localparam int IRQ_RESET_REQ   = 1;
   localparam int IRQ_HOLD        = 2;
   localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;

   // state register fields
   localparam int STATE_LATCH     = 0;
   localparam int STATE_PHASE     = 1;   // three bits, one-hot phase
   localparam int STATE_SELFTEST  = 4;
   localparam int STATE_HOLD      = 5;

   // power-up phase of the status pin, one-hot
   typedef enum logic [2:0] {
      PH_HIZ  = 3'b001,
      PH_STAB = 3'b010,
      PH_RUN  = 3'b100
   } phase_t;

   // fault conditions reported by the sensing core
   typedef struct packed {
      logic parity;
      logic over_temp;
      logic clk_freq;
      logic terminal;
   } fault_t;

   // one filtered sample pair from the processing path
   typedef struct packed {
      logic [DATA_W-1:0] x;
      logic [DATA_W-1:0] y;
   } sample_t;

endpackage

// ===== rtl/pin_edge_sync.sv
// two-flop pin synchroniser with rising-edge pulse
`timescale 1ns/1ns
module pin_edge_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin,
   output logic      level,
   output logic      rise
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // first stage feeds only the second stage, so no logic sees a metastable value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // edge taken between the settled stages
   assign level = sync_reg;
   assign rise  = sync_reg & ~prev_reg;

endmodule

// ===== rtl/accel_ctrl.sv
// acceleration sensor control: reset request, status latch, self-test, capture/hold, apb
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ns
module accel_ctrl
   import accel_ctrl_pkg::*;
#(
   parameter int RESET_CYCLES = RESET_REQ_CYC,
   parameter int HIZ_CYCLES   = STATUS_HIZ_CYC,
   parameter int STAB_CYCLES  = STAB_DELAY_CYC
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [accel_ctrl_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                  pwdata,
   output logic [31:0]                       prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic                         reset_pin_n,
   input  wire logic                         sclk_pin,
   input  wire logic                         self_test_pin,
   input  wire logic                         capture_hold_pin,
   input  wire accel_ctrl_pkg::fault_t       faults,
   input  wire accel_ctrl_pkg::sample_t      filtered,
   output logic                              status_out,
   output logic                              status_oe,
   output logic                              self_test_active,
   output logic                              self_test_polarity_bit,
   output logic                              spi_enable,
   output logic [accel_ctrl_pkg::DATA_W-1:0] x_axis_output,
   output logic [accel_ctrl_pkg::DATA_W-1:0] y_axis_output,
   output logic                              irq
);
   import accel_ctrl_pkg::*;

   logic [NUM_PINS-1:0]     pin_raw;
   logic [NUM_PINS-1:0]     pin_level;
   logic [NUM_PINS-1:0]     pin_rise;
   logic                    req_active;
   logic [CNT_W-1:0]        req_cnt_reg;
   logic                    int_reset_reg;
   phase_t                  phase_reg;
   phase_t                  phase_next;
   logic [CNT_W-1:0]        phase_cnt_reg;
   logic                    latch_reg;
   logic                    latch_set;
   logic                    latch_clr;
   logic                    any_fault;
   logic [SAMPLE_CNT_W-1:0] sample_cnt_reg;
   logic                    sample_tick_reg;
   logic [1:0]              ctrl_reg;
   logic [IRQ_W-1:0]        irq_status_reg;
   logic [IRQ_W-1:0]        irq_mask_reg;
   logic [IRQ_W-1:0]        irq_event;
   logic                    latch_prev_reg;
   logic                    setup_phase;
   logic                    wr_access;
   logic                    addr_ok;
   logic [31:0]             rd_value;

   // self-test and hold pins pass through their own synchronisers
   assign pin_raw[PIN_SELF_TEST] = self_test_pin;
   assign pin_raw[PIN_HOLD]      = capture_hold_pin;

   generate
      for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
         pin_edge_sync u_sync (
            .pclk    (pclk),
            .presetn (presetn),
            .pin     (pin_raw[i]),
            .level   (pin_level[i]),
            .rise    (pin_rise[i])
         );
      end
   endgenerate

   // reset request: both levels must hold without a break for the full time
   assign req_active = ~reset_pin_n & sclk_pin;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_cnt_reg   <= '0;
         int_reset_reg <= 1'b0;
      end else if (!req_active) begin
         req_cnt_reg   <= '0;
         int_reset_reg <= 1'b0;
      end else if (req_cnt_reg == CNT_W'(RESET_CYCLES - 1)) begin
         req_cnt_reg   <= '0; // a pin held longer asks again after another full period
         int_reset_reg <= 1'b1;
      end else begin
         req_cnt_reg   <= req_cnt_reg + 1'b1;
         int_reset_reg <= 1'b0;
      end
   end

   // status pin phase: float, then driven high through stabilization, then run
   always_comb begin
      phase_next = phase_reg;
      case (phase_reg)
         PH_HIZ: begin
            if (phase_cnt_reg == CNT_W'(HIZ_CYCLES - 1)) begin
               phase_next = PH_STAB;
            end
         end
         PH_STAB: begin
            if (phase_cnt_reg == CNT_W'(STAB_CYCLES - 1)) begin
               phase_next = PH_RUN;
            end
         end
         PH_RUN: begin
            phase_next = PH_RUN;
         end
         default: begin
            phase_next = PH_HIZ;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg     <= PH_HIZ;
         phase_cnt_reg <= '0;
      end else if (int_reset_reg) begin
         phase_reg     <= PH_HIZ;
         phase_cnt_reg <= '0;
      end else begin
         phase_reg     <= phase_next;
         phase_cnt_reg <= (phase_next != phase_reg) ? '0 : phase_cnt_reg + 1'b1;
      end
   end

   // status latch: set wins over clear, so a lasting fault shows again at once
   assign any_fault = faults.parity | faults.over_temp | faults.clk_freq | faults.terminal;
   assign latch_set = any_fault | int_reset_reg | (phase_reg != PH_RUN);
   assign latch_clr = pin_rise[PIN_SELF_TEST] & (phase_reg == PH_RUN);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_reg <= 1'b1;
      end else if (latch_set) begin
         latch_reg <= 1'b1;
      end else if (latch_clr) begin
         latch_reg <= 1'b0;
      end
   end

   // status pin drive; the latch is held high through float and stabilization
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_out <= 1'b0;
         status_oe  <= 1'b0;
      end else begin
         status_out <= latch_reg | latch_set;
         status_oe  <= (phase_next != PH_HIZ) & ~int_reset_reg;
      end
   end

   // self-test stimulus follows the synchronised pin level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         self_test_active       <= 1'b0;
         self_test_polarity_bit <= 1'b0;
         spi_enable             <= 1'b0;
      end else begin
         self_test_active       <= pin_level[PIN_SELF_TEST];
         self_test_polarity_bit <= ctrl_reg[CTRL_POLARITY];
         spi_enable             <= ctrl_reg[CTRL_TEST_MODE];
      end
   end

   // sample timer of the processing path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_cnt_reg  <= '0;
         sample_tick_reg <= 1'b0;
      end else if (sample_cnt_reg == SAMPLE_CNT_W'(SAMPLE_CYC - 1)) begin
         sample_cnt_reg  <= '0;
         sample_tick_reg <= 1'b1;
      end else begin
         sample_cnt_reg  <= sample_cnt_reg + 1'b1;
         sample_tick_reg <= 1'b0;
      end
   end

   // held result per axis, one converter code each; frozen while hold is high except that an internal reset zeroes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_axis_output <= '0;
         y_axis_output <= '0;
      end else if (int_reset_reg) begin
         x_axis_output <= '0;
         y_axis_output <= '0;
      end else if (sample_tick_reg && !pin_level[PIN_HOLD]) begin
         x_axis_output <= filtered.x;
         y_axis_output <= filtered.y;
      end
   end

   // apb: answer loaded in setup so the access phase sees pready at once
   assign setup_phase = psel & ~penable;
   assign wr_access   = psel & penable & pready & pwrite & ~pslverr;

   always_comb begin
      addr_ok  = 1'b1;
      rd_value = '0;
      case (paddr)
         CTRL_ADDR:  rd_value[1:0] = ctrl_reg;
         IRQ_ADDR:   rd_value[IRQ_W-1:0] = irq_status_reg;
         MASK_ADDR:  rd_value[IRQ_W-1:0] = irq_mask_reg;
         STATE_ADDR: begin
            rd_value[STATE_LATCH]       = latch_reg;
            rd_value[STATE_PHASE +: 3]  = phase_reg;
            rd_value[STATE_SELFTEST]    = pin_level[PIN_SELF_TEST];
            rd_value[STATE_HOLD]        = pin_level[PIN_HOLD];
         end
         XDATA_ADDR: rd_value[DATA_W-1:0] = x_axis_output;
         YDATA_ADDR: rd_value[DATA_W-1:0] = y_axis_output;
         default:    addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setup_phase;
         pslverr <= setup_phase & ~addr_ok;
         prdata  <= (setup_phase && !pwrite && addr_ok) ? rd_value : '0;
      end
   end

   // writable control and mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg     <= CTRL_RESET;
         irq_mask_reg <= MASK_RESET;
      end else if (wr_access) begin
         if (paddr == CTRL_ADDR) begin
            ctrl_reg <= pwdata[1:0];
         end
         if (paddr == MASK_ADDR) begin
            irq_mask_reg <= pwdata[IRQ_W-1:0];
         end
      end
   end

   // sticky events, write one to clear; a new event wins over its clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_prev_reg <= 1'b0;
      end else begin
         latch_prev_reg <= latch_reg;
      end
   end

   assign irq_event[IRQ_STATUS_SET] = latch_reg & ~latch_prev_reg;
   assign irq_event[IRQ_RESET_REQ]  = int_reset_reg;
   assign irq_event[IRQ_HOLD]       = pin_rise[PIN_HOLD];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= '0;
      end else if (wr_access && paddr == IRQ_ADDR) begin
         irq_status_reg <= (irq_status_reg & ~pwdata[IRQ_W-1:0]) | irq_event;
      end else begin
         irq_status_reg <= irq_status_reg | irq_event;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_status_reg | irq_event) & irq_mask_reg);
      end
   end

   // checks kept beside the logic they guard
   sequence req_broken;
      !req_active;
   endsequence

   sequence hiz_to_stab;
      (phase_reg == PH_HIZ) ##1 (phase_reg == PH_STAB);
   endsequence

   a_reset_after_hold: assert property (@(posedge pclk) disable iff (!presetn)
      int_reset_reg |-> $past(req_cnt_reg) == CNT_W'(RESET_CYCLES - 1) && $past(req_active))
      else $error("internal reset without full request time");

   a_request_count_restart: assert property (@(posedge pclk) disable iff (!presetn)
      req_broken |=> req_cnt_reg == '0 && !int_reset_reg)
      else $error("request count not restarted");

   a_status_float_phase: assert property (@(posedge pclk) disable iff (!presetn)
      int_reset_reg |=> !status_oe [*8])
      else $error("status driven right after reset");

   a_status_drive_high: assert property (@(posedge pclk) disable iff (!presetn)
      hiz_to_stab |-> status_oe && status_out)
      else $error("status not driven high after float");

   a_stab_ignores_clear: assert property (@(posedge pclk) disable iff (!presetn)
      phase_reg == PH_STAB |=> status_out && latch_reg)
      else $error("status cleared during stabilization");

   a_self_test_clear: assert property (@(posedge pclk) disable iff (!presetn)
      latch_clr && !latch_set |=> !latch_reg ##1 !status_out || latch_reg)
      else $error("self-test edge did not clear status latch");

   a_fault_sets_status: assert property (@(posedge pclk) disable iff (!presetn)
      any_fault |=> status_out && latch_reg)
      else $error("fault present but status low");

   a_self_test_level: assert property (@(posedge pclk) disable iff (!presetn)
      pin_level[PIN_SELF_TEST] |=> self_test_active)
      else $error("self-test stimulus not active");

   a_track_sample: assert property (@(posedge pclk) disable iff (!presetn)
      sample_tick_reg && !pin_level[PIN_HOLD] && !int_reset_reg
      |=> x_axis_output == $past(filtered.x) && y_axis_output == $past(filtered.y))
      else $error("held data missed a new sample");

   a_hold_freezes_data: assert property (@(posedge pclk) disable iff (!presetn)
      pin_level[PIN_HOLD] && !int_reset_reg |=> $stable(x_axis_output) && $stable(y_axis_output))
      else $error("data changed while hold high");

   a_sample_period: assert property (@(posedge pclk) disable iff (!presetn)
      sample_tick_reg |=> !sample_tick_reg [*8])
      else $error("sample strobes too close");

   a_apb_error_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      setup_phase && !addr_ok |=> pready && pslverr)
      else $error("unmapped address not refused");

endmodule

// ===== sim/sys_ctrl_model.sv
// system controller model: reset request, self-test and capture/hold pins
`timescale 1ns/1ns
module sys_ctrl_model (
   input  wire logic pclk,
   output logic      reset_pin_n,
   output logic      sclk_pin,
   output logic      self_test_pin,
   output logic      capture_hold_pin
);
   // idle levels: reset pin pulled up, serial clock low, hold tied low
   initial begin
      reset_pin_n = 1'b1;
      sclk_pin = 1'b0;
      self_test_pin = 1'b0;
      capture_hold_pin = 1'b0;
   end

   // low-to-high on the self-test pin, held long enough to pass the sync
   task automatic st_pulse();
      @(posedge pclk);
      self_test_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      self_test_pin <= 1'b0;
      @(posedge pclk);
      // return off the edge so callers look at settled outputs
      @(negedge pclk);
   endtask

   task automatic set_pin(input logic st, input logic hold);
      @(posedge pclk);
      self_test_pin <= st;
      capture_hold_pin <= hold;
   endtask

   // reset pin low with clock high for n cycles, then one of them breaks
   task automatic reset_req(input int n, input logic by_sclk);
      @(posedge pclk);
      reset_pin_n <= 1'b0;
      sclk_pin <= 1'b1;
      repeat (n) @(posedge pclk);
      if (by_sclk)
         sclk_pin <= 1'b0;
      else
         reset_pin_n <= 1'b1;
      @(posedge pclk);
      reset_pin_n <= 1'b1;
      sclk_pin <= 1'b0;
   endtask
endmodule

// ===== sim/accel_ctrl_tb.sv
// self-checking bench for the acceleration sensor control block
`timescale 1ns/1ns
module accel_ctrl_tb;
   import accel_ctrl_pkg::*;
   localparam int RST_CYC = 8;
   localparam int HIZ_CYC = 10;
   localparam int STAB_CYC = 20;
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              reset_pin_n;
   logic              sclk_pin;
   logic              self_test_pin;
   logic              capture_hold_pin;
   fault_t            faults;
   sample_t           filtered;
   logic              status_out;
   logic              status_oe;
   logic              self_test_active;
   logic              self_test_polarity_bit;
   logic              spi_enable;
   logic [DATA_W-1:0] x_axis_output;
   logic [DATA_W-1:0] y_axis_output;
   logic              irq;
   logic [31:0]       rd;
   logic [31:0]       rnd;
   logic              err;
   logic [23:0]       held;
   int                fail_count;
   int                samples_checked;
   int                seed;
   int                cnt;
   int                i;

   always #20 pclk = ~pclk;

   accel_ctrl #(.RESET_CYCLES(RST_CYC), .HIZ_CYCLES(HIZ_CYC), .STAB_CYCLES(STAB_CYC))
      u_accel_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reset_pin_n(reset_pin_n), .sclk_pin(sclk_pin), .self_test_pin(self_test_pin),
      .capture_hold_pin(capture_hold_pin), .faults(faults), .filtered(filtered),
      .status_out(status_out), .status_oe(status_oe), .self_test_active(self_test_active),
      .self_test_polarity_bit(self_test_polarity_bit), .spi_enable(spi_enable),
      .x_axis_output(x_axis_output), .y_axis_output(y_axis_output), .irq(irq));

   sys_ctrl_model u_sys_ctrl_model (
      .pclk(pclk), .reset_pin_n(reset_pin_n), .sclk_pin(sclk_pin),
      .self_test_pin(self_test_pin), .capture_hold_pin(capture_hold_pin));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("mismatches %0d, checks %0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge pclk);
   endtask

   // one apb transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         fail_count++;
         end_sim();
      end
   endtask

   task automatic wait_status(input logic exp, input int bound);
      int n;
      n = 0;
      while (status_out !== exp && n < bound) begin
         @(negedge pclk);
         n++;
      end
      check("status_out", status_out, exp);
      if (status_out !== exp)
         end_sim();
   endtask

   // float phase: status pin released, then driven within a bounded time
   task automatic wait_float();
      cnt = 0;
      while (status_oe !== 1'b1 && cnt < HIZ_CYC + 20) begin
         @(negedge pclk);
         cnt++;
      end
      check("float_len", cnt >= HIZ_CYC - 6 && cnt <= HIZ_CYC + 3, 1);
      check("out_driven", status_out, 1);
      if (cnt >= HIZ_CYC + 20)
         end_sim();
   endtask

   // both axes must follow the newest sample within 410 cycles, one sample period of 400 plus ten
   task automatic wait_data();
      int n;
      n = 0;
      while ({x_axis_output, y_axis_output} !== filtered && n < 410) begin
         @(negedge pclk);
         n++;
      end
      check("track", {x_axis_output, y_axis_output}, filtered);
      if (n >= 410)
         end_sim();
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      faults = 4'h0;
      filtered = 24'h000000;
      fail_count = 0;
      samples_checked = 0;
      seed = 32'h6b4bd0c6;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // first edge after release loads the status flops
      cycles(2);
      check("oe_float", status_oe, 0);
      check("out_init", status_out, 1);
      wait_float();
      // a clear during stabilization must be ignored
      u_sys_ctrl_model.st_pulse();
      check("stab_clear", status_out, 1);
      apb(0, STATE_ADDR, 0);
      check("phase_stab", rd[3:1], 3'b010);
      apb(0, CTRL_ADDR, 0);
      check("ctrl_rst", rd, 0);
      check("spi_rst", spi_enable, 0);
      apb(0, MASK_ADDR, 0);
      check("mask_rst", rd, 0);
      cycles(STAB_CYC + 4);
      apb(0, STATE_ADDR, 0);
      check("phase_run", rd[3:1], 3'b100);
      u_sys_ctrl_model.st_pulse();
      wait_status(0, 8);
      // each fault source sets status; clearing while it persists sets it again
      for (i = 0; i < 4; i++) begin
         @(posedge pclk);
         faults <= fault_t'(4'h1 << i);
         wait_status(1, 4);
         u_sys_ctrl_model.st_pulse();
         check("fault_kept", status_out, 1);
         @(posedge pclk);
         faults <= fault_t'(4'h0);
         u_sys_ctrl_model.st_pulse();
         wait_status(0, 8);
      end
      // latch-rose event: masked on, then cleared by writing one
      apb(1, MASK_ADDR, 1);
      cycles(2);
      check("irq_on", irq, 1);
      apb(1, IRQ_ADDR, 1);
      cycles(2);
      check("irq_clr", irq, 0);
      apb(1, MASK_ADDR, 0);
      // self-test level and every control setting
      for (i = 0; i < 4; i++) begin
         apb(1, CTRL_ADDR, i);
         u_sys_ctrl_model.set_pin(1'b1, 1'b0);
         cycles(1);
         check("st_sync", self_test_active, 0);
         cycles(4);
         check("st_active", self_test_active, 1);
         check("polarity", self_test_polarity_bit, i[0]);
         check("spi_en", spi_enable, i[1]);
         u_sys_ctrl_model.set_pin(1'b0, 1'b0);
         cycles(4);
         check("st_idle", self_test_active, 0);
      end
      apb(1, CTRL_ADDR, 0);
      for (i = 0; i < 3; i++) begin
         rnd = $random(seed);
         @(posedge pclk);
         filtered <= rnd[23:0];
         cycles(1);
         wait_data();
      end
      // freeze: later samples must not reach the outputs while hold is high
      u_sys_ctrl_model.set_pin(1'b0, 1'b1);
      cycles(4);
      held = filtered;
      rnd = $random(seed) ^ 32'h00800000;
      @(posedge pclk);
      filtered <= rnd[23:0];
      cycles(820);
      check("frozen", {x_axis_output, y_axis_output}, held);
      apb(0, IRQ_ADDR, 0);
      check("irq_hold", rd[2], 1);
      u_sys_ctrl_model.set_pin(1'b0, 1'b0);
      wait_data();
      // broken reset requests never reach the full count
      @(posedge pclk);
      filtered <= 24'h000000;
      apb(1, IRQ_ADDR, 32'h00000007);
      u_sys_ctrl_model.reset_req(RST_CYC - 3, 1'b0);
      u_sys_ctrl_model.reset_req(RST_CYC - 3, 1'b1);
      cycles(4);
      check("no_reset", status_oe, 1);
      u_sys_ctrl_model.reset_req(RST_CYC + 2, 1'b0);
      cycles(1);
      check("reset_float", status_oe, 0);
      check("irq_masked", irq, 0);
      // float is timed from the internal reset, before any bus traffic
      wait_float();
      apb(0, IRQ_ADDR, 0);
      check("irq_req", rd[1], 1);
      apb(1, MASK_ADDR, 2);
      cycles(2);
      check("irq_req_on", irq, 1);
      apb(1, IRQ_ADDR, 2);
      cycles(2);
      check("irq_req_clr", irq, 0);
      // unmapped place refused, read-only data ignores writes
      apb(1, 8'h20, 32'hffffffff);
      check("slverr_w", err, 1);
      apb(0, 8'h20, 0);
      check("slverr_r", err, 1);
      check("unmapped_rd", rd, 0);
      apb(1, XDATA_ADDR, 32'h00000fff);
      check("ro_err", err, 0);
      apb(0, XDATA_ADDR, 0);
      check("ro_data", rd, 0);
      end_sim();
   end
endmodule
